// [hw/dsync_defs.vh]
// constants for the display sync timing generator
`ifndef DSYNC_DEFS_VH
`define DSYNC_DEFS_VH

// register byte offsets
`define DSYNC_CTRL_OFS    8'h00
`define DSYNC_DIV_OFS     8'h04
`define DSYNC_LINE_OFS    8'h08
`define DSYNC_ACTW_OFS    8'h0c
`define DSYNC_FRAME_OFS   8'h10
`define DSYNC_ACTH_OFS    8'h14
`define DSYNC_SWID_OFS    8'h18
`define DSYNC_EOFS_OFS    8'h1c
`define DSYNC_SRD_OFS     8'h20
`define DSYNC_SWR_OFS     8'h24
`define DSYNC_STAT_OFS    8'h28

// field positions
`define DSYNC_CTRL_EN     0
`define DSYNC_CTRL_SGL    1
`define DSYNC_DIV_FRAC    3:0
`define DSYNC_DIV_INT     11:4
`define DSYNC_DIV_CPP     19:16
`define DSYNC_LO16        15:0
`define DSYNC_HI16        31:16
`define DSYNC_B0          7:0
`define DSYNC_B1          15:8
`define DSYNC_B2          23:16
`define DSYNC_B3          31:24
`define DSYNC_SWR_RW      30
`define DSYNC_SWR_GO      31

// reset values
`define DSYNC_DIV_RST     32'h0001_0020
`define DSYNC_LINE_RST    32'h0004_0020
`define DSYNC_ACTW_RST    32'h0000_0010
`define DSYNC_FRAME_RST   32'h0002_0010
`define DSYNC_ACTH_RST    32'h0000_0008
`define DSYNC_SWID_RST    32'h0004_0004
`define DSYNC_SRD_RST     32'h0006_0208
`define DSYNC_SWR_RST     32'h0000_0008

`define DSYNC_HTRANS_NSQ  2'b10
`define DSYNC_ONE8        8'h01
`define DSYNC_ONE16       16'h0001

`endif

// [hw/dsync_wave.v]
// waveform counter: offset plus rising and falling positions after a trigger
`timescale 1ns/1ps
`default_nettype none
module dsync_wave #(
   parameter W = 16
) (
   input  wire         sys_clk,
   input  wire         nrst,
   input  wire         trig,
   input  wire [W-1:0] offset,
   input  wire [W-1:0] rise_pos,
   input  wire [W-1:0] fall_pos,
   output reg          wave_r
);
   reg  [W-1:0] cnt_r;
   reg          run_r;
   wire [W-1:0] up_at;
   wire [W-1:0] dn_at;

   assign up_at = offset + rise_pos;
   assign dn_at = offset + fall_pos;

   // a new trigger restarts the count, so offset plus width must fit one period
   always @(posedge sys_clk) begin
      if (!nrst) begin
         cnt_r  <= {W{1'b0}};
         run_r  <= 1'b0;
         wave_r <= 1'b0;
      end else if (trig) begin
         cnt_r  <= {{(W-1){1'b0}}, 1'b1};
         run_r  <= 1'b1;
         wave_r <= (up_at == {W{1'b0}}) && (dn_at != {W{1'b0}});
      end else if (run_r) begin
         cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
         if (cnt_r == up_at)
            wave_r <= 1'b1;
         if (cnt_r == dn_at) begin
            wave_r <= 1'b0;
            run_r  <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [hw/dsync_gen.v]
// display sync timing generator with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "dsync_defs.vh"
module dsync_gen #(
   parameter DW = 24
) (
   input  wire          sys_clk,
   input  wire          nrst,
   input  wire          hsel,
   input  wire [31:0]   haddr,
   input  wire [1:0]    htrans,
   input  wire          hwrite,
   input  wire [2:0]    hsize,
   input  wire [31:0]   hwdata,
   input  wire          hready,
   output reg           hreadyout,
   output reg           hresp,
   output reg  [31:0]   hrdata,
   input  wire [DW-1:0] pixel_in,
   output reg           pixel_take_r,
   output reg  [DW-1:0] pixel_out_r,
   output wire          display_interface_clock_out,
   output wire          line_sync,
   output wire          frame_sync,
   output wire          data_valid_strobe,
   output reg           serial_sel_n_r,
   output reg           serial_clk_r,
   output reg           serial_rw_r
);
   localparam S_IDLE = 3'b001;
   localparam S_ACC  = 3'b010;
   localparam S_GAP  = 3'b100;

   reg  [31:0] ctrl_r, div_r, line_r, actw_r, frame_r, acth_r;
   reg  [31:0] swid_r, eofs_r, srd_r, swr_r;
   reg  [7:0]  waddr_r;
   reg         wr_pend_r;
   reg  [31:0] rd_nxt;

   // timing state, divider counts in double-rate steps of sys_clk, hcnt_r and vcnt_r in interface clocks and lines
   reg  [8:0]  half_cnt_r;
   reg  [8:0]  per_half_r;
   reg  [3:0]  frac_acc_r;
   reg  [3:0]  comp_cnt_r;
   reg  [15:0] hcnt_r;
   reg  [15:0] vcnt_r;
   reg  [4:0]  frac_sum;
   reg         ic_tick;
   reg         line_due, frame_due, act_now;
   reg         dv_trig_r;

   reg  [2:0]  sstate_r;
   reg  [7:0]  scnt_r;
   reg  [1:0]  gap_ticks_r;
   reg         go_pend_r;
   reg         go_rw_r;
   wire        en;
   wire        sgl;
   wire [7:0]  s_per, s_up, s_dn;
   wire [15:0] ic_half;
   wire        bus_req;
   wire [7:0]  n_up, n_dn;
   wire        n_low0;

   assign en      = ctrl_r[`DSYNC_CTRL_EN];
   assign sgl     = ctrl_r[`DSYNC_CTRL_SGL];
   assign bus_req = hsel & hready & (htrans == `DSYNC_HTRANS_NSQ);
   assign ic_half = {8'h00, per_half_r[8:1]};

   // ---------------- ahb-lite slave, zero wait state ----------------
   always @* begin
      case (haddr[7:0])
         `DSYNC_CTRL_OFS:  rd_nxt = ctrl_r;
         `DSYNC_DIV_OFS:   rd_nxt = div_r;
         `DSYNC_LINE_OFS:  rd_nxt = line_r;
         `DSYNC_ACTW_OFS:  rd_nxt = actw_r;
         `DSYNC_FRAME_OFS: rd_nxt = frame_r;
         `DSYNC_ACTH_OFS:  rd_nxt = acth_r;
         `DSYNC_SWID_OFS:  rd_nxt = swid_r;
         `DSYNC_EOFS_OFS:  rd_nxt = eofs_r;
         `DSYNC_SRD_OFS:   rd_nxt = srd_r;
         `DSYNC_SWR_OFS:   rd_nxt = {go_pend_r | ~sstate_r[0], swr_r[30:0]};
         `DSYNC_STAT_OFS:  rd_nxt = {vcnt_r, hcnt_r};
         default:          rd_nxt = 32'h0000_0000;
      endcase
      if (haddr[31:8] != 24'h00_0000)
         rd_nxt = 32'h0000_0000;
   end

   always @(posedge sys_clk) begin
      if (!nrst) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         waddr_r   <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_r <= bus_req & hwrite & (haddr[31:8] == 24'h00_0000);
         waddr_r   <= haddr[7:0];
         if (bus_req & ~hwrite)
            hrdata <= rd_nxt;
      end
   end

   always @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_r  <= 32'h0000_0000;
         div_r   <= `DSYNC_DIV_RST;
         line_r  <= `DSYNC_LINE_RST;
         actw_r  <= `DSYNC_ACTW_RST;
         frame_r <= `DSYNC_FRAME_RST;
         acth_r  <= `DSYNC_ACTH_RST;
         swid_r  <= `DSYNC_SWID_RST;
         eofs_r  <= 32'h0000_0000;
         srd_r   <= `DSYNC_SRD_RST;
         swr_r   <= `DSYNC_SWR_RST;
      end else if (wr_pend_r) begin
         case (waddr_r)
            `DSYNC_CTRL_OFS:  ctrl_r  <= {30'h0, hwdata[1:0]};
            `DSYNC_DIV_OFS:   div_r   <= {12'h000, hwdata[19:16], 4'h0, hwdata[11:0]};
            `DSYNC_LINE_OFS:  line_r  <= hwdata;
            `DSYNC_ACTW_OFS:  actw_r  <= {16'h0000, hwdata[`DSYNC_LO16]};
            `DSYNC_FRAME_OFS: frame_r <= hwdata;
            `DSYNC_ACTH_OFS:  acth_r  <= {16'h0000, hwdata[`DSYNC_LO16]};
            `DSYNC_SWID_OFS:  swid_r  <= hwdata;
            `DSYNC_EOFS_OFS:  eofs_r  <= hwdata;
            `DSYNC_SRD_OFS:   srd_r   <= {8'h00, hwdata[23:0]};
            `DSYNC_SWR_OFS:   swr_r   <= {1'b0, hwdata[30], 22'h0, hwdata[`DSYNC_B0]};
            default:          ctrl_r  <= ctrl_r;
         endcase
      end
   end

   // ---------------- fractional interface clock divider ----------------
   // the fraction accumulates in sixteenths; a carry stretches one period by a base clock
   always @* begin
      frac_sum = {1'b0, frac_acc_r} + {1'b0, div_r[`DSYNC_DIV_FRAC]};
      ic_tick  = en && (half_cnt_r == 9'h000);
   end

   always @(posedge sys_clk) begin
      if (!nrst || !en) begin
         half_cnt_r <= 9'h000;
         per_half_r <= 9'h002;
         frac_acc_r <= 4'h0;
      end else if (ic_tick) begin
         // period in double-rate steps = 2 * (floor + carry)
         per_half_r <= {div_r[`DSYNC_DIV_INT] + {7'h00, frac_sum[4]}, 1'b0};
         half_cnt_r <= {div_r[`DSYNC_DIV_INT] + {7'h00, frac_sum[4]}, 1'b0} - 9'h001;
         frac_acc_r <= frac_sum[3:0];
      end else begin
         half_cnt_r <= half_cnt_r - 9'h001;
      end
   end

   // output clock: high for the first half period, edges moved by the offset
   dsync_wave #(.W(16)) u_clk_wave (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .trig     (ic_tick),
      .offset   ({8'h00, eofs_r[`DSYNC_B0]}),
      .rise_pos (16'h0000),
      .fall_pos (ic_half),
      .wave_r   (display_interface_clock_out)
   );

   // ---------------- pixel, line and frame counters ----------------
   always @* begin
      line_due  = ic_tick && (hcnt_r == 16'h0000);
      frame_due = line_due && (vcnt_r == 16'h0000);
      // active window: front blank first, trailing blank is what remains of the total
      act_now   = (hcnt_r >= line_r[`DSYNC_HI16]) &&
                  (hcnt_r < line_r[`DSYNC_HI16] + actw_r[`DSYNC_LO16]) &&
                  (vcnt_r >= frame_r[`DSYNC_HI16]) &&
                  (vcnt_r < frame_r[`DSYNC_HI16] + acth_r[`DSYNC_LO16]);
   end

   always @(posedge sys_clk) begin
      if (!nrst || !en) begin
         hcnt_r       <= 16'h0000;
         vcnt_r       <= 16'h0000;
         comp_cnt_r   <= 4'h0;
         pixel_take_r <= 1'b0;
         pixel_out_r  <= {DW{1'b0}};
         dv_trig_r    <= 1'b0;
      end else begin
         pixel_take_r <= 1'b0;
         dv_trig_r    <= 1'b0;
         if (ic_tick) begin
            if (hcnt_r + `DSYNC_ONE16 >= line_r[`DSYNC_LO16]) begin
               hcnt_r <= 16'h0000;
               if (vcnt_r + `DSYNC_ONE16 >= frame_r[`DSYNC_LO16])
                  vcnt_r <= 16'h0000;
               else
                  vcnt_r <= vcnt_r + `DSYNC_ONE16;
            end else begin
               hcnt_r <= hcnt_r + `DSYNC_ONE16;
            end
            if (act_now) begin
               // a new pixel is taken on its first component clock only
               if (comp_cnt_r == 4'h0) begin
                  pixel_out_r  <= pixel_in;
                  pixel_take_r <= 1'b1;
               end
               dv_trig_r <= 1'b1;
               if (comp_cnt_r + 4'h1 >= div_r[`DSYNC_DIV_CPP])
                  comp_cnt_r <= 4'h0;
               else
                  comp_cnt_r <= comp_cnt_r + 4'h1;
            end else begin
               comp_cnt_r <= 4'h0;
            end
         end
      end
   end

   // line sync: width and offset in double-rate steps
   dsync_wave #(.W(16)) u_line_wave (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .trig     (line_due),
      .offset   ({8'h00, eofs_r[`DSYNC_B1]}),
      .rise_pos (16'h0000),
      .fall_pos (swid_r[`DSYNC_LO16]),
      .wave_r   (line_sync)
   );

   dsync_wave #(.W(16)) u_frame_wave (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .trig     (frame_due),
      .offset   ({8'h00, eofs_r[`DSYNC_B2]}),
      .rise_pos (16'h0000),
      .fall_pos (swid_r[`DSYNC_HI16]),
      .wave_r   (frame_sync)
   );

   // strobe starts counting once the data register has been loaded
   dsync_wave #(.W(16)) u_dv_wave (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .trig     (dv_trig_r),
      .offset   ({8'h00, eofs_r[`DSYNC_B3]}),
      .rise_pos (16'h0000),
      .fall_pos (ic_half),
      .wave_r   (data_valid_strobe)
   );

   // ---------------- asynchronous serial access engine ----------------
   // read and write each have their own cycle period; the read clock is low
   // between its rise and fall positions
   assign s_per = go_rw_r ? srd_r[`DSYNC_B0] : swr_r[`DSYNC_B0];
   assign s_up  = go_rw_r ? srd_r[`DSYNC_B1] : 8'h00;
   assign s_dn  = go_rw_r ? srd_r[`DSYNC_B2] : {1'b0, swr_r[7:1]};
   // count zero of an access is driven at its start edge, before go_rw_r has moved,
   // so the level there is decided from the queued direction
   assign n_up   = swr_r[`DSYNC_SWR_RW] ? srd_r[`DSYNC_B1] : 8'h00;
   assign n_dn   = swr_r[`DSYNC_SWR_RW] ? srd_r[`DSYNC_B2] : {1'b0, swr_r[7:1]};
   assign n_low0 = (n_up == 8'h00) && (n_dn != 8'h00);

   always @(posedge sys_clk) begin
      if (!nrst) begin
         sstate_r       <= S_IDLE;
         scnt_r         <= 8'h00;
         gap_ticks_r    <= 2'b00;
         go_pend_r      <= 1'b0;
         go_rw_r        <= 1'b0;
         serial_sel_n_r <= 1'b1;
         serial_clk_r   <= 1'b1;
         serial_rw_r    <= 1'b0;
      end else begin
         case (sstate_r)
            S_IDLE: begin
               serial_sel_n_r <= 1'b1;
               serial_clk_r   <= 1'b1;
               if (go_pend_r) begin
                  go_pend_r      <= 1'b0;
                  go_rw_r        <= swr_r[`DSYNC_SWR_RW];
                  serial_rw_r    <= swr_r[`DSYNC_SWR_RW];
                  serial_sel_n_r <= 1'b0;
                  serial_clk_r   <= !n_low0;
                  scnt_r         <= 8'h00;
                  sstate_r       <= S_ACC;
               end
            end
            S_ACC: begin
               scnt_r       <= scnt_r + `DSYNC_ONE8;
               // low from rise position up to fall position
               serial_clk_r <= !((scnt_r + `DSYNC_ONE8 >= s_up) &&
                                 (scnt_r + `DSYNC_ONE8 < s_dn));
               if (scnt_r + `DSYNC_ONE8 >= s_per) begin
                  serial_clk_r <= 1'b1;
                  if (sgl) begin
                     serial_sel_n_r <= 1'b1;
                     gap_ticks_r    <= 2'b00;
                     sstate_r       <= S_GAP;
                  end else if (!go_pend_r) begin
                     serial_sel_n_r <= 1'b1;
                     sstate_r       <= S_IDLE;
                  end else begin
                     // back-to-back access keeps select low
                     go_pend_r   <= 1'b0;
                     go_rw_r     <= swr_r[`DSYNC_SWR_RW];
                     serial_rw_r <= swr_r[`DSYNC_SWR_RW];
                     serial_clk_r <= !n_low0;
                     scnt_r      <= 8'h00;
                  end
               end
            end
            S_GAP: begin
               // idle spans a whole interface clock: from one tick to the next
               serial_sel_n_r <= 1'b1;
               serial_clk_r   <= 1'b1;
               if (ic_tick || !en)
                  gap_ticks_r <= gap_ticks_r + 2'b01;
               if (gap_ticks_r == 2'b10 || !en)
                  sstate_r <= S_IDLE;
            end
            default: sstate_r <= S_IDLE;
         endcase
         // a start written in the cycle a pending one is accepted must not be lost
         if (wr_pend_r && (waddr_r == `DSYNC_SWR_OFS) && hwdata[`DSYNC_SWR_GO])
            go_pend_r <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// [verification/dsync_gen_chk.sv]
// port-level assertions for the display sync timing generator
`timescale 1ns/1ps
`default_nettype none
module dsync_gen_chk #(
   parameter DW = 24
) (
   input wire logic          sys_clk,
   input wire logic          nrst,
   input wire logic          hsel,
   input wire logic [31:0]   haddr,
   input wire logic [1:0]    htrans,
   input wire logic          hwrite,
   input wire logic [2:0]    hsize,
   input wire logic [31:0]   hwdata,
   input wire logic          hready,
   input wire logic          hreadyout,
   input wire logic          hresp,
   input wire logic [31:0]   hrdata,
   input wire logic [DW-1:0] pixel_in,
   input wire logic          pixel_take_r,
   input wire logic [DW-1:0] pixel_out_r,
   input wire logic          display_interface_clock_out,
   input wire logic          line_sync,
   input wire logic          frame_sync,
   input wire logic          data_valid_strobe,
   input wire logic          serial_sel_n_r,
   input wire logic          serial_clk_r,
   input wire logic          serial_rw_r
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_ahb_ready: assert property (hreadyout) else $error("wait state inserted");
   a_ahb_okay: assert property (!hresp) else $error("non okay response");
   a_unmapped_zero: assert property (hsel && hready && htrans == 2'b10 && !hwrite
      && haddr[31:8] != 24'h0 |=> hrdata == 32'h0) else $error("unmapped read not zero");
   a_take_pulse: assert property (pixel_take_r |=> !pixel_take_r)
      else $error("pixel take longer than a cycle");
   a_pixel_pass: assert property (pixel_take_r |-> pixel_out_r == $past(pixel_in))
      else $error("pixel out differs from sampled input");
   a_line_width: assert property ($rose(line_sync) |-> line_sync [*4] ##1 !line_sync)
      else $error("line sync width wrong");
   a_frame_width: assert property ($rose(frame_sync) |-> frame_sync [*4] ##1 !frame_sync)
      else $error("frame sync width wrong");
   a_ser_rw_hold: assert property (!serial_sel_n_r && !$past(serial_sel_n_r)
      |-> $stable(serial_rw_r)) else $error("direction changed inside access");
   a_ser_clk_idle: assert property (serial_sel_n_r |-> serial_clk_r)
      else $error("serial clock low outside access");
   a_ser_wr_len: assert property ($fell(serial_sel_n_r) && !serial_rw_r
      |-> !serial_sel_n_r [*8] ##1 serial_sel_n_r) else $error("write access length wrong");
endmodule
`default_nettype wire

// [verification/dsync_panel.sv]
// display panel model: measures sync spacing, strobes and serial accesses
`timescale 1ns/1ps
`default_nettype none
module dsync_panel (
   input wire logic   sys_clk,
   input wire logic   nrst,
   input wire logic   clk_in,
   input wire logic   ls,
   input wire logic   fs,
   input wire logic   dv,
   input wire logic   take,
   input wire logic   sel_n,
   input wire logic   sclk,
   input wire logic   rw,
   output logic [31:0] lper,
   output logic [31:0] fper,
   output logic [31:0] gap,
   output logic [31:0] fgap,
   output logic [31:0] dvc,
   output logic [31:0] tkc,
   output logic [31:0] ckmin,
   output logic [31:0] ckmax,
   output logic [31:0] slen,
   output logic [31:0] clow,
   output logic [31:0] sgap,
   output logic        rw_seen
);
   logic [31:0] cyc, tls, tfs, tck, dn, tn, mn, mx, sc, cc, hc;
   logic        pls, pfs, pck, pdv, psel, fl, ff;
   // per-frame figures are latched at frame sync so a partial frame is never read
   always @(posedge sys_clk) begin
      {pls, pfs, pck, pdv, psel} <= {ls, fs, clk_in, dv, sel_n};
      if (!nrst) begin
         cyc <= 32'h0;
         sc <= 32'h0;
         cc <= 32'h0;
         hc <= 32'h0;
      end else begin
         cyc <= cyc + 32'h1;
         if (ls && !pls) begin
            lper <= cyc - tls;
            tls <= cyc;
            fl <= 1'b1;
         end
         if (dv && !pdv) begin
            dn <= dn + 32'h1;
            if (fl) gap <= cyc - tls;
            if (ff) fgap <= cyc - tfs;
            fl <= 1'b0;
            ff <= 1'b0;
         end
         if (take) tn <= tn + 32'h1;
         if (clk_in && !pck) begin
            tck <= cyc;
            if (cyc - tck < mn) mn <= cyc - tck;
            if (cyc - tck > mx) mx <= cyc - tck;
         end
         if (fs && !pfs) begin
            fper <= cyc - tfs;
            tfs <= cyc;
            ff <= 1'b1;
            {dvc, tkc, ckmin, ckmax} <= {dn, tn, mn, mx};
            {dn, tn, mn, mx} <= {32'h0, 32'h0, 32'hffff_ffff, 32'h0};
         end
         if (!sel_n) begin
            sc <= sc + 32'h1;
            cc <= cc + {31'h0, !sclk};
            rw_seen <= rw;
         end
         if (sel_n && !psel) begin
            {slen, clow} <= {sc, cc};
            {sc, cc, hc} <= {32'h0, 32'h0, 32'h0};
         end else if (sel_n) hc <= hc + 32'h1;
         if (!sel_n && psel) sgap <= hc;
      end
   end
endmodule
`default_nettype wire

// [verification/tb_dsync_gen.sv]
// self-checking bench for the display sync timing generator
`timescale 1ns/1ps
`default_nettype none
`include "dsync_defs.vh"
module tb_dsync_gen;
   logic sys_clk = 1'b0, nrst, hsel, hwrite, hreadyout, hresp, pixel_take_r;
   logic ck, ls, fs, dv, sel_n, sclk, srw, rws;
   logic [31:0] haddr, hwdata, hrdata, rd, g0, f0;
   logic [31:0] lper, fper, gap, fgap, dvc, tkc, ckmin, ckmax, slen, clow, sgap;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [23:0] pixel_in = 24'h0, pixel_out_r;
   int fail_count = 0, checks = 0;
   logic [7:0] rofs [10] = '{`DSYNC_CTRL_OFS, `DSYNC_DIV_OFS, `DSYNC_LINE_OFS, `DSYNC_ACTW_OFS,
      `DSYNC_FRAME_OFS, `DSYNC_ACTH_OFS, `DSYNC_SWID_OFS, `DSYNC_EOFS_OFS, `DSYNC_SRD_OFS,
      `DSYNC_SWR_OFS};
   logic [31:0] rrst [10] = '{32'h0, `DSYNC_DIV_RST, `DSYNC_LINE_RST, `DSYNC_ACTW_RST,
      `DSYNC_FRAME_RST, `DSYNC_ACTH_RST, `DSYNC_SWID_RST, 32'h0, `DSYNC_SRD_RST, `DSYNC_SWR_RST};
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) pixel_in <= pixel_in + 24'h010203;
   dsync_gen i_dsync_gen (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pixel_in(pixel_in),
      .pixel_take_r(pixel_take_r), .pixel_out_r(pixel_out_r),
      .display_interface_clock_out(ck), .line_sync(ls), .frame_sync(fs),
      .data_valid_strobe(dv), .serial_sel_n_r(sel_n), .serial_clk_r(sclk), .serial_rw_r(srw));
   dsync_panel i_dsync_panel (.sys_clk(sys_clk), .nrst(nrst), .clk_in(ck), .ls(ls), .fs(fs),
      .dv(dv), .take(pixel_take_r), .sel_n(sel_n), .sclk(sclk), .rw(srw), .lper(lper),
      .fper(fper), .gap(gap), .fgap(fgap), .dvc(dvc), .tkc(tkc), .ckmin(ckmin), .ckmax(ckmax),
      .slen(slen), .clow(clow), .sgap(sgap), .rw_seen(rws));
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // hready is sampled every phase even though this slave never stretches
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= `DSYNC_HTRANS_NSQ;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task wr(input logic [7:0] o, input logic [31:0] d);
      ahb(1'b1, {24'h0, o}, d, rd);
   endtask
   task cfg(input logic [31:0] dvr, ln, aw, fr, ah, eo);
      wr(`DSYNC_DIV_OFS, dvr);
      wr(`DSYNC_LINE_OFS, ln);
      wr(`DSYNC_ACTW_OFS, aw);
      wr(`DSYNC_FRAME_OFS, fr);
      wr(`DSYNC_ACTH_OFS, ah);
      wr(`DSYNC_EOFS_OFS, eo);
      repeat (2) @(posedge fs);
      repeat (3) @(posedge sys_clk);
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      fail_count++;
      report_and_stop;
   end
   initial begin
      {nrst, hsel, hwrite, haddr, hwdata, htrans, hsize} = {3'h0, 64'h0, 5'h2};
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      for (int i = 0; i < 10; i++) begin
         ahb(1'b0, {24'h0, rofs[i]}, 32'h0, rd);
         chk(rd, rrst[i]);
      end
      ahb(1'b1, 32'h0000_0100, 32'hffff_ffff, rd);
      ahb(1'b0, 32'h0000_0100, 32'h0, rd);
      chk(rd, 32'h0);
      wr(`DSYNC_CTRL_OFS, 32'hffff_ffff);
      ahb(1'b0, 32'h0, 32'h0, rd);
      chk(rd, 32'h3);
      wr(`DSYNC_CTRL_OFS, 32'h1);
      cfg(`DSYNC_DIV_RST, `DSYNC_LINE_RST, 32'h10, `DSYNC_FRAME_RST, 32'h8, 32'h0);
      {g0, f0} = {gap, fgap};
      chk(lper, 32'd128);
      chk(fper, 32'd2048);
      chk(dvc, 32'd128);
      chk(tkc, 32'd128);
      chk(ckmin, 32'd4);
      chk(ckmax, 32'd4);
      cfg(`DSYNC_DIV_RST, 32'h0006_0020, 32'h10, `DSYNC_FRAME_RST, 32'h8, 32'h0);
      chk(gap, g0 + 32'd8);
      chk(lper, 32'd128);
      cfg(`DSYNC_DIV_RST, `DSYNC_LINE_RST, 32'h10, 32'h0003_0010, 32'h8, 32'h0);
      chk(fgap, f0 + 32'd128);
      chk(fper, 32'd2048);
      cfg(`DSYNC_DIV_RST, `DSYNC_LINE_RST, 32'h8, `DSYNC_FRAME_RST, 32'h4, 32'h0);
      chk(dvc, 32'd32);
      chk(lper, 32'd128);
      chk(fper, 32'd2048);
      cfg(`DSYNC_DIV_RST, `DSYNC_LINE_RST, 32'h10, `DSYNC_FRAME_RST, 32'h8, 32'h0105_0301);
      chk(gap, g0 - 32'd2);
      chk(fgap, f0 - 32'd4);
      chk(ckmax, 32'd4);
      cfg(32'h0002_0020, `DSYNC_LINE_RST, 32'h10, `DSYNC_FRAME_RST, 32'h8, 32'h0);
      chk(tkc, 32'd64);
      chk(dvc, 32'd128);
      cfg(32'h0001_0028, `DSYNC_LINE_RST, 32'h10, `DSYNC_FRAME_RST, 32'h8, 32'h0);
      chk(fper, 32'd2560);
      chk(lper, 32'd160);
      chk(ckmin, 32'd4);
      chk(ckmax, 32'd6);
      // second start lands while the first access runs and must wait its turn
      wr(`DSYNC_SRD_OFS, 32'h0006_020a);
      wr(`DSYNC_CTRL_OFS, 32'h3);
      wr(`DSYNC_SWR_OFS, 32'h8000_0008);
      wr(`DSYNC_SWR_OFS, 32'h8000_0008);
      repeat (60) @(posedge sys_clk);
      chk(slen, 32'd8);
      chk(clow, 32'd4);
      chk({31'h0, rws}, 32'h0);
      chk({31'h0, sgap >= 32'd4}, 32'h1);
      wr(`DSYNC_SWR_OFS, 32'hc000_0008);
      repeat (40) @(posedge sys_clk);
      chk(slen, 32'd10);
      chk(clow, 32'd4);
      chk({31'h0, rws}, 32'h1);
      // without single access mode the engine goes straight back to idle
      wr(`DSYNC_CTRL_OFS, 32'h1);
      wr(`DSYNC_SWR_OFS, 32'h8000_0008);
      repeat (30) @(posedge sys_clk);
      chk(slen, 32'd8);
      chk(clow, 32'd4);
      chk({31'h0, rws}, 32'h0);
      report_and_stop;
   end
endmodule
bind dsync_gen dsync_gen_chk #(.DW(DW)) i_dsync_gen_chk (.sys_clk(sys_clk), .nrst(nrst),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .pixel_in(pixel_in), .pixel_take_r(pixel_take_r), .pixel_out_r(pixel_out_r),
   .display_interface_clock_out(display_interface_clock_out), .line_sync(line_sync),
   .frame_sync(frame_sync), .data_valid_strobe(data_valid_strobe),
   .serial_sel_n_r(serial_sel_n_r), .serial_clk_r(serial_clk_r), .serial_rw_r(serial_rw_r));
`default_nettype wire
